// File: hw/occh_pkg.sv
// Shared constants and types for the output compare channel
package occh_pkg;
    localparam int OCCH_CW = 16;

    // APB byte addresses of the channel registers
    localparam logic [7:0] OCCH_ADDR_CTRL = 8'h00;
    localparam logic [7:0] OCCH_ADDR_PRI = 8'h04;
    localparam logic [7:0] OCCH_ADDR_SEC = 8'h08;
    localparam logic [7:0] OCCH_ADDR_STAT = 8'h0C;
    localparam logic [7:0] OCCH_ADDR_MASK = 8'h10;

    // Control word field positions
    localparam int OCCH_BIT_IDLE = 13;
    localparam int OCCH_BIT_FAULT = 4;
    localparam int OCCH_BIT_TSEL = 3;
    localparam int OCCH_MODE_LSB = 0;

    // Status and mask bit positions
    localparam int OCCH_STAT_CMP = 0;
    localparam int OCCH_STAT_FLT = 1;
    localparam int OCCH_NUM_EVT = 2;

    // Values after reset
    localparam logic [15:0] OCCH_CMP_RST = 16'h0000;
    localparam logic [1:0] OCCH_EVT_RST = 2'h0;
    localparam logic OCCH_PIN_RST = 1'b0;
    localparam logic OCCH_SYNC_RST = 1'b1;

    // Compare modes
    localparam logic [2:0] OCCH_MODE_OFF = 3'h0;
    localparam logic [2:0] OCCH_MODE_SET_HI = 3'h1;
    localparam logic [2:0] OCCH_MODE_SET_LO = 3'h2;
    localparam logic [2:0] OCCH_MODE_TOGGLE = 3'h3;
    localparam logic [2:0] OCCH_MODE_PULSE = 3'h4;
    localparam logic [2:0] OCCH_MODE_CONT = 3'h5;
    localparam logic [2:0] OCCH_MODE_PWM = 3'h6;
    localparam logic [2:0] OCCH_MODE_PWM_FLT = 3'h7;

    typedef struct packed {
        logic idle_stop_select;
        logic time_base_select;
        logic [2:0] compare_mode_field;
    } occh_ctrl_t;

    localparam occh_ctrl_t OCCH_CTRL_RST = 5'h00;

    typedef enum logic [1:0] {
        OCCH_PH_WAIT,
        OCCH_PH_HIGH,
        OCCH_PH_DONE
    } occh_phase_t;
endpackage

// File: hw/occh_sync.sv
// Three-stage pin synchroniser that accepts a level once stages two and three agree
module occh_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= occh_pkg::OCCH_SYNC_RST;
            s2_q <= occh_pkg::OCCH_SYNC_RST;
            s3_q <= occh_pkg::OCCH_SYNC_RST;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= occh_pkg::OCCH_SYNC_RST;
        end else if (s2_q == s3_q) begin
            sync_out <= s3_q;
        end
    end
endmodule // occh_sync

// File: hw/occh_irq.sv
// Sticky event status with mask and a single level interrupt
module occh_irq (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] evt_set,
    input wire logic [1:0] evt_clear,
    input wire logic mask_wr,
    input wire logic [1:0] mask_wdata,
    output logic [1:0] status_q,
    output logic [1:0] mask_q,
    output logic irq
);
    // Set wins over a read-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= occh_pkg::OCCH_EVT_RST;
        end else begin
            status_q <= (status_q & ~evt_clear) | evt_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= occh_pkg::OCCH_EVT_RST;
        end else if (mask_wr) begin
            mask_q <= mask_wdata;
        end
    end

    assign irq = |(status_q & mask_q);
endmodule // occh_irq

// File: hw/occh_channel.sv
// Output compare channel with APB registers, pulse and PWM generation
//
// Decided for this implementation: the APB register port and the register offsets.
module occh_channel #(
    parameter bit FAULT_IRQ_EN = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] base_a_count,
    input wire logic [15:0] base_b_count,
    input wire logic base_a_rollover,
    input wire logic base_b_rollover,
    input wire logic cpu_idle,
    input wire logic fault_input_a,
    output logic compare_output_pin,
    output logic compare_output_en,
    output logic irq
);
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] t);
        return a == t;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        return addr_is(a, occh_pkg::OCCH_ADDR_CTRL) || addr_is(a, occh_pkg::OCCH_ADDR_PRI)
            || addr_is(a, occh_pkg::OCCH_ADDR_SEC) || addr_is(a, occh_pkg::OCCH_ADDR_STAT)
            || addr_is(a, occh_pkg::OCCH_ADDR_MASK);
    endfunction

    occh_pkg::occh_ctrl_t ctrl_q;
    occh_pkg::occh_phase_t phase_q;
    occh_pkg::occh_phase_t phase_d;
    logic [15:0] pri_q;
    logic [15:0] sec_q;
    logic [2:0] last_mode_q;
    logic pin_q;
    logic pin_d;
    logic fault_q;
    logic fault_d;
    logic oe_q;
    logic m1_prev_q;
    logic m2_prev_q;
    logic flt_prev_q;
    logic flt_s;
    logic evt_cmp;
    logic evt_flt;
    logic [31:0] rdata_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;

    logic setup_c;
    logic access_c;
    logic wr_c;
    logic halted;
    logic [15:0] count;
    logic rollover;
    logic m1_now;
    logic m2_now;
    logic m1_hit;
    logic m2_hit;
    logic flt_fall;
    logic mode_new;
    logic is_pwm;
    logic [2:0] mode;

    assign setup_c = psel && !penable;
    assign access_c = psel && penable;
    assign wr_c = access_c && pwrite && addr_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = access_c && !addr_mapped(paddr);
    assign prdata = rdata_q;

    assign mode = ctrl_q.compare_mode_field;
    assign halted = ctrl_q.idle_stop_select && cpu_idle;
    assign count = ctrl_q.time_base_select ? base_b_count : base_a_count;
    assign rollover = ctrl_q.time_base_select ? base_b_rollover : base_a_rollover;
    assign m1_now = count == pri_q;
    assign m2_now = count == sec_q;
    // A count held for many clocks by a prescaler still matches only once
    assign m1_hit = m1_now && !m1_prev_q;
    assign m2_hit = m2_now && !m2_prev_q;
    assign flt_fall = flt_prev_q && !flt_s;
    assign mode_new = mode != last_mode_q;
    assign is_pwm = mode == occh_pkg::OCCH_MODE_PWM || mode == occh_pkg::OCCH_MODE_PWM_FLT;

    occh_sync u_fault_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(fault_input_a),
        .sync_out(flt_s)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= occh_pkg::OCCH_CTRL_RST;
        end else if (wr_c && addr_is(paddr, occh_pkg::OCCH_ADDR_CTRL)) begin
            ctrl_q <= {pwdata[occh_pkg::OCCH_BIT_IDLE], pwdata[occh_pkg::OCCH_BIT_TSEL],
                pwdata[occh_pkg::OCCH_MODE_LSB +: 3]};
        end
    end

    // Hardware reload takes priority over a software write to primary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_q <= occh_pkg::OCCH_CMP_RST;
        end else if (is_pwm && rollover && !halted && !mode_new) begin
            pri_q <= sec_q;
        end else if (wr_c && addr_is(paddr, occh_pkg::OCCH_ADDR_PRI)) begin
            pri_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_q <= occh_pkg::OCCH_CMP_RST;
        end else if (wr_c && addr_is(paddr, occh_pkg::OCCH_ADDR_SEC)) begin
            sec_q <= pwdata[15:0];
        end
    end

    always_comb begin
        pin_d = pin_q;
        phase_d = phase_q;
        fault_d = fault_q;
        evt_cmp = 1'b0;
        evt_flt = 1'b0;
        if (mode_new) begin
            phase_d = occh_pkg::OCCH_PH_WAIT;
            fault_d = 1'b0;
            case (mode)
                occh_pkg::OCCH_MODE_SET_HI: pin_d = 1'b0;
                occh_pkg::OCCH_MODE_SET_LO: pin_d = 1'b1;
                occh_pkg::OCCH_MODE_PULSE,
                occh_pkg::OCCH_MODE_CONT: pin_d = 1'b0;
                occh_pkg::OCCH_MODE_PWM,
                occh_pkg::OCCH_MODE_PWM_FLT: pin_d = pri_q != 16'h0000;
                default: pin_d = pin_q;
            endcase
        end else if (!halted) begin
            case (mode)
                occh_pkg::OCCH_MODE_SET_HI,
                occh_pkg::OCCH_MODE_SET_LO: begin
                    if (phase_q == occh_pkg::OCCH_PH_WAIT && m1_hit) begin
                        pin_d = mode == occh_pkg::OCCH_MODE_SET_HI;
                        phase_d = occh_pkg::OCCH_PH_DONE;
                        evt_cmp = 1'b1;
                    end
                end
                occh_pkg::OCCH_MODE_TOGGLE: begin
                    if (m1_hit) begin
                        pin_d = !pin_q;
                        evt_cmp = 1'b1;
                    end
                end
                occh_pkg::OCCH_MODE_PULSE,
                occh_pkg::OCCH_MODE_CONT: begin
                    if (phase_q == occh_pkg::OCCH_PH_WAIT && m1_hit) begin
                        pin_d = 1'b1;
                        phase_d = occh_pkg::OCCH_PH_HIGH;
                    end else if (phase_q == occh_pkg::OCCH_PH_HIGH && m2_hit) begin
                        pin_d = 1'b0;
                        evt_cmp = 1'b1;
                        phase_d = (mode == occh_pkg::OCCH_MODE_PULSE) ?
                            occh_pkg::OCCH_PH_DONE : occh_pkg::OCCH_PH_WAIT;
                    end
                end
                occh_pkg::OCCH_MODE_PWM,
                occh_pkg::OCCH_MODE_PWM_FLT: begin
                    if (rollover) begin
                        // Fault latch releases at a period start with the input high, or on a mode change
                        if (flt_s) begin
                            fault_d = 1'b0;
                        end
                        pin_d = (sec_q != 16'h0000) && !(fault_q && !flt_s);
                    end else if (m1_hit) begin
                        pin_d = 1'b0;
                    end
                    if (mode == occh_pkg::OCCH_MODE_PWM_FLT && flt_fall) begin
                        fault_d = 1'b1;
                        pin_d = 1'b0;
                        evt_flt = FAULT_IRQ_EN;
                    end
                end
                default: pin_d = pin_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= occh_pkg::OCCH_PIN_RST;
            phase_q <= occh_pkg::OCCH_PH_WAIT;
            fault_q <= 1'b0;
            last_mode_q <= occh_pkg::OCCH_MODE_OFF;
        end else begin
            pin_q <= pin_d;
            phase_q <= phase_d;
            fault_q <= fault_d;
            last_mode_q <= mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m1_prev_q <= 1'b0;
            m2_prev_q <= 1'b0;
            flt_prev_q <= occh_pkg::OCCH_SYNC_RST;
        end else if (!halted) begin
            m1_prev_q <= m1_now;
            m2_prev_q <= m2_now;
            flt_prev_q <= flt_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= mode != occh_pkg::OCCH_MODE_OFF;
        end
    end

    assign compare_output_pin = pin_q;
    assign compare_output_en = oe_q;

    // Read data is latched in the setup cycle; status clear uses exactly those bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup_c && !pwrite) begin
            rdata_q <= 32'h0000_0000;
            if (addr_is(paddr, occh_pkg::OCCH_ADDR_CTRL)) begin
                rdata_q[occh_pkg::OCCH_BIT_IDLE] <= ctrl_q.idle_stop_select;
                rdata_q[occh_pkg::OCCH_BIT_FAULT] <= fault_q;
                rdata_q[occh_pkg::OCCH_BIT_TSEL] <= ctrl_q.time_base_select;
                rdata_q[occh_pkg::OCCH_MODE_LSB +: 3] <= mode;
            end else if (addr_is(paddr, occh_pkg::OCCH_ADDR_PRI)) begin
                rdata_q[15:0] <= pri_q;
            end else if (addr_is(paddr, occh_pkg::OCCH_ADDR_SEC)) begin
                rdata_q[15:0] <= sec_q;
            end else if (addr_is(paddr, occh_pkg::OCCH_ADDR_STAT)) begin
                rdata_q[1:0] <= status_q;
            end else if (addr_is(paddr, occh_pkg::OCCH_ADDR_MASK)) begin
                rdata_q[1:0] <= mask_q;
            end
        end
    end

    occh_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .evt_set({evt_flt, evt_cmp}),
        .evt_clear((access_c && !pwrite && addr_is(paddr, occh_pkg::OCCH_ADDR_STAT)) ?
            rdata_q[1:0] : 2'h0),
        .mask_wr(wr_c && addr_is(paddr, occh_pkg::OCCH_ADDR_MASK)),
        .mask_wdata(pwdata[1:0]),
        .status_q(status_q),
        .mask_q(mask_q),
        .irq(irq)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_run(logic [2:0] m);
        mode == m && !mode_new && !halted;
    endsequence
    sequence s_rd_ctrl;
        setup_c && !pwrite && addr_is(paddr, occh_pkg::OCCH_ADDR_CTRL);
    endsequence

    AST_TIME_BASE: assert property (ctrl_q.time_base_select |-> count == base_b_count)
        else $error("wrong time base selected");
    AST_OFF_RELEASE: assert property (mode == occh_pkg::OCCH_MODE_OFF |=> !compare_output_en
        && !evt_cmp)
        else $error("disabled channel drives pin");
    AST_SET_HIGH: assert property (s_run(occh_pkg::OCCH_MODE_SET_HI) ##0
        (phase_q == occh_pkg::OCCH_PH_WAIT && m1_hit) |=> compare_output_pin && status_q[0])
        else $error("mode 001 match did not raise pin");
    AST_SET_LOW: assert property (s_run(occh_pkg::OCCH_MODE_SET_LO) ##0
        (phase_q == occh_pkg::OCCH_PH_WAIT && m1_hit) |=> !compare_output_pin)
        else $error("mode 010 match did not lower pin");
    AST_TOGGLE: assert property (s_run(occh_pkg::OCCH_MODE_TOGGLE) ##0 m1_hit
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("toggle missed");
    AST_PULSE_FALL: assert property (s_run(occh_pkg::OCCH_MODE_PULSE) ##0
        (phase_q == occh_pkg::OCCH_PH_HIGH && m2_hit) |=> !compare_output_pin
        && phase_q == occh_pkg::OCCH_PH_DONE)
        else $error("single pulse did not end");
    AST_PWM_NO_IRQ: assert property (mode == occh_pkg::OCCH_MODE_PWM |-> !evt_cmp && !evt_flt)
        else $error("interrupt event in plain PWM");
    AST_PWM_LOAD: assert property ((s_run(occh_pkg::OCCH_MODE_PWM) ##0 rollover)
        |=> pri_q == $past(sec_q))
        else $error("duty not reloaded at rollover");
    AST_FAULT: assert property (s_run(occh_pkg::OCCH_MODE_PWM_FLT) ##0 flt_fall
        |=> fault_q && !compare_output_pin)
        else $error("fault did not force pin low");
    AST_HALT: assert property ((halted && !mode_new) |=> $stable(compare_output_pin)
        || $past(mode_new))
        else $error("pin moved while halted");
    AST_RSVD_ZERO: assert property (s_rd_ctrl |=> prdata[15:14] == 2'h0
        && prdata[12:5] == 8'h00)
        else $error("reserved control bits not zero");
endmodule // occh_channel

// File: verif/occh_far_model.sv
// Far-side model: two time bases feeding the channel and the pin pad with a pull-down
module occh_far_model #(
    parameter int PERIOD = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run_a,
    input wire logic run_b,
    input wire logic compare_output_pin,
    input wire logic compare_output_en,
    output logic [15:0] base_a_count,
    output logic [15:0] base_b_count,
    output logic base_a_rollover,
    output logic base_b_rollover,
    output logic pad
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] LAST = 16'(PERIOD - 1);

    // A stopped base parks at zero so every run starts from a known count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_a_count <= 16'h0000;
        end else begin
            base_a_count <= (run_a && base_a_count != LAST) ? base_a_count + 16'h0001 : 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_b_count <= 16'h0000;
        end else begin
            base_b_count <= (run_b && base_b_count != LAST) ? base_b_count + 16'h0001 : 16'h0000;
        end
    end

    assign base_a_rollover = run_a && (base_a_count == LAST);
    assign base_b_rollover = run_b && (base_b_count == LAST);
    // Released pin is pulled low, so a stale driven level never shows
    assign pad = compare_output_en ? compare_output_pin : 1'h0;
endmodule // occh_far_model

// File: verif/tb_output_compare_channel.sv
// Self-checking bench for the output compare channel over APB
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_output_compare_channel;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic run_a = 1'h0;
    logic run_b = 1'h0;
    logic cpu_idle = 1'h0;
    logic fault_input_a = 1'h1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] base_a_count;
    logic [15:0] base_b_count;
    logic base_a_rollover;
    logic base_b_rollover;
    logic compare_output_pin;
    logic compare_output_en;
    logic irq;
    logic pad;
    logic last_err;
    logic [31:0] rd_q;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    always #5 pclk = ~pclk;

    occh_channel #(.FAULT_IRQ_EN(1'h1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .base_a_count(base_a_count),
        .base_b_count(base_b_count), .base_a_rollover(base_a_rollover),
        .base_b_rollover(base_b_rollover), .cpu_idle(cpu_idle), .fault_input_a(fault_input_a),
        .compare_output_pin(compare_output_pin), .compare_output_en(compare_output_en), .irq(irq));

    occh_far_model #(.PERIOD(16)) far (.pclk(pclk), .presetn(presetn), .run_a(run_a),
        .run_b(run_b), .compare_output_pin(compare_output_pin),
        .compare_output_en(compare_output_en), .base_a_count(base_a_count),
        .base_b_count(base_b_count), .base_a_rollover(base_a_rollover),
        .base_b_rollover(base_b_rollover), .pad(pad));

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Waits for the slave however long it takes; only the cycle ceiling ends a hang
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd_q = prdata;
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'h1, d);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'h0, 32'h0);
        `CHK(nm, e, rd_q)
    endtask

    task automatic run_set(input logic a, input logic b);
        @(posedge pclk);
        run_a <= a;
        run_b <= b;
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge pclk);
    endtask

    // Bounded wait on the pad or the interrupt, then compare
    task automatic wait_on(input logic use_irq, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (((use_irq ? irq : pad) !== v) && n < 200);
        `CHK(use_irq ? "irq" : "pad", v, use_irq ? irq : pad)
    endtask

    // Control is only rewritten with both bases stopped
    task automatic set_mode(input logic [31:0] c);
        run_set(1'h0, 1'h0);
        wr(occh_pkg::OCCH_ADDR_CTRL, c);
        idle(4);
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        rd("ctrl", occh_pkg::OCCH_ADDR_CTRL, 32'h0);
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h0);
        rd("mask", occh_pkg::OCCH_ADDR_MASK, 32'h0);
        wr(occh_pkg::OCCH_ADDR_CTRL, 32'hFFFFFFFF);
        rd("ctrl", occh_pkg::OCCH_ADDR_CTRL, 32'h0000200F);
        `CHK("slverr", 1'h0, last_err)
        set_mode(32'h0);
        `CHK("en", 1'h0, compare_output_en)
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h0);
        rd("hole", 8'h14, 32'h0);
        `CHK("slverr", 1'h1, last_err)
        wr(occh_pkg::OCCH_ADDR_PRI, 32'h5);
        wr(occh_pkg::OCCH_ADDR_MASK, 32'h3);
        // Rising one-shot on base a
        set_mode(32'h1);
        `CHK("pad", 1'h0, pad)
        run_set(1'h1, 1'h0);
        wait_on(1'h0, 1'h1);
        `CHK("cnt_a", 16'h0006, base_a_count)
        `CHK("irq", 1'h1, irq)
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h1);
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h0);
        // Falling one-shot on base b; base a must be ignored
        set_mode(32'h0000000A);
        `CHK("pad", 1'h1, pad)
        run_set(1'h1, 1'h0);
        idle(40);
        `CHK("pad", 1'h1, pad)
        run_set(1'h0, 1'h1);
        wait_on(1'h0, 1'h0);
        `CHK("cnt_b", 16'h0006, base_b_count)
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h1);
        // Toggle keeps the low level on entry
        set_mode(32'h3);
        `CHK("pad", 1'h0, pad)
        run_set(1'h1, 1'h0);
        wait_on(1'h0, 1'h1);
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h1);
        wait_on(1'h0, 1'h0);
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h1);
        // Single delayed pulse
        wr(occh_pkg::OCCH_ADDR_SEC, 32'h9);
        set_mode(32'h4);
        run_set(1'h1, 1'h0);
        wait_on(1'h0, 1'h1);
        `CHK("cnt_a", 16'h0006, base_a_count)
        wait_on(1'h0, 1'h0);
        `CHK("cnt_a", 16'h000A, base_a_count)
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h1);
        idle(40);
        `CHK("pad", 1'h0, pad)
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h0);
        // Continuous pulses
        set_mode(32'h5);
        run_set(1'h1, 1'h0);
        repeat (2) begin
            wait_on(1'h0, 1'h1);
            wait_on(1'h0, 1'h0);
        end
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h1);
        // PWM without fault: duty reload at rollover
        wr(occh_pkg::OCCH_ADDR_SEC, 32'h3);
        wr(occh_pkg::OCCH_ADDR_PRI, 32'h7);
        set_mode(32'h6);
        `CHK("pad", 1'h1, pad)
        run_set(1'h1, 1'h0);
        for (int i = 0; i < 40 && base_a_rollover !== 1'h1; i++) @(negedge pclk);
        wait_on(1'h0, 1'h1);
        wait_on(1'h0, 1'h0);
        `CHK("cnt_a", 16'h0004, base_a_count)
        rd("pri", occh_pkg::OCCH_ADDR_PRI, 32'h3);
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h0);
        // PWM with fault
        set_mode(32'h7);
        run_set(1'h1, 1'h0);
        idle(20);
        @(posedge pclk);
        fault_input_a <= 1'h0;
        wait_on(1'h1, 1'h1);
        `CHK("pad", 1'h0, pad)
        rd("ctrl", occh_pkg::OCCH_ADDR_CTRL, 32'h00000017);
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h2);
        @(posedge pclk);
        fault_input_a <= 1'h1;
        idle(40);
        rd("ctrl", occh_pkg::OCCH_ADDR_CTRL, 32'h00000007);
        // Halt while the CPU idles
        @(posedge pclk);
        cpu_idle <= 1'h1;
        set_mode(32'h00002001);
        run_set(1'h1, 1'h0);
        idle(40);
        `CHK("pad", 1'h0, pad)
        rd("stat", occh_pkg::OCCH_ADDR_STAT, 32'h0);
        @(posedge pclk);
        cpu_idle <= 1'h0;
        wait_on(1'h0, 1'h1);
        run_set(1'h0, 1'h0);
        give_verdict();
    end
endmodule // tb_output_compare_channel
